// ---- inc/nvsc_regs.vh ----
// constants for the nonvolatile sram host controller
`ifndef NVSC_REGS_VH
`define NVSC_REGS_VH
`define NVSC_SEQ_A1 15'h0E38
`define NVSC_SEQ_A2 15'h31C7
`define NVSC_SEQ_A3 15'h03E0
`define NVSC_SEQ_A4 15'h3C1F
`define NVSC_SEQ_A5 15'h303F
`define NVSC_SEQ_SAVE 15'h0FC0
`define NVSC_SEQ_RESTORE 15'h0C63
`define NVSC_CMD_READ 3'h0
`define NVSC_CMD_WRITE 3'h1
`define NVSC_CMD_SAVE 3'h2
`define NVSC_CMD_RESTORE 3'h3
`define NVSC_CMD_HW_SAVE 3'h4
`define NVSC_CLK_NS 100
`define NVSC_ACCESS_NS 200
`define NVSC_SAVE_US 10000
`define NVSC_RESTORE_US 20
`define NVSC_HSB_PULSE_NS 100
`define NVSC_SAVE_START_NS 1000
`define NVSC_STEPS 6
`endif

// ---- logic/nvsc_host.v ----
// host controller driving a byte-wide sram with nonvolatile shadow
`timescale 1ns/1ps
`include "nvsc_regs.vh"
// Summary of operation
// (R1) save sequence uses six reads only
// (R2) no other access inside a sequence
// (R3) write enable high during sequence steps
// (R4) sixth address picks save or restore
// (R5) sequence addresses fixed, last selects operation
// (R6) one chip-select pulse per step
// (R7) device counts short select pulses
// (R8) device ignores inputs during save
// (R9) device erases then programs in parallel
// (R10) device blocks sram access while nonvolatile
// (R11) read: select, output enable low
// (R12) hold controls until read data taken
// (R13) write: address stable while select low
// (R14) data valid before write-ending edge
// (R15) output enable kept high during writes
// (R16) device saves itself on supply loss
// (R17) save also requested via busy line
// (R18) device skips unneeded hardware saves
// (R19) device stays off until busy line high
// (R20) software save always performed
// (R21) device restores after supply recovers
// (R22) never hold write state at power-up
// (R23) busy line low marks save in progress
// (R24) software operation runs to completion
// (R25) device restarts sequence on mismatch
module nvsc_host #(
    parameter ACC_CYC = `NVSC_ACCESS_NS / `NVSC_CLK_NS,
    parameter SAVE_CYC = `NVSC_SAVE_US * 1000 / `NVSC_CLK_NS,
    parameter RESTORE_CYC = `NVSC_RESTORE_US * 1000 / `NVSC_CLK_NS,
    parameter HSB_CYC = `NVSC_HSB_PULSE_NS / `NVSC_CLK_NS,
    parameter START_CYC = (`NVSC_SAVE_START_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS
) (
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // command port
    input wire cmd_valid,
    input wire [2:0] cmd_op,
    input wire [14:0] cmd_addr,
    input wire [7:0] cmd_wdata,
    output reg cmd_ready,
    output reg rsp_valid,
    output reg [7:0] rsp_rdata,
    // memory pins
    output reg [14:0] address_bus,
    output reg [7:0] data_lines_out,
    output reg data_lines_oe,
    input wire [7:0] data_lines_in,
    output reg chip_select_n,
    output reg output_enable_n,
    output reg write_enable_n,
    output reg save_busy_line_n_out,
    output reg save_busy_line_n_oe,
    input wire save_busy_line_n_in
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ACCESS = 3'h1;
    localparam ST_GAP = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_HSB = 3'h4;
    localparam ST_BUSY = 3'h5;

    reg [2:0] state;
    reg [2:0] op;
    reg [2:0] step;
    reg [23:0] cnt;
    reg [7:0] d_meta;
    reg [7:0] d_sync;
    reg b_meta;
    reg b_sync;
    reg [14:0] seq_addr;

    // sequence address of the current step
    always @* begin
        case (step)
            3'h0: seq_addr = `NVSC_SEQ_A1; // [R5]
            3'h1: seq_addr = `NVSC_SEQ_A2;
            3'h2: seq_addr = `NVSC_SEQ_A3;
            3'h3: seq_addr = `NVSC_SEQ_A4;
            3'h4: seq_addr = `NVSC_SEQ_A5;
            default: seq_addr = (op == `NVSC_CMD_SAVE) ?
                `NVSC_SEQ_SAVE : `NVSC_SEQ_RESTORE; // [R4]
        endcase
    end

    always @(posedge mclk) begin
        d_meta <= data_lines_in;
        d_sync <= d_meta;
        b_meta <= save_busy_line_n_in;
        b_sync <= b_meta;
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            op <= 3'h0;
            step <= 3'h0;
            cnt <= 24'h000000;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            address_bus <= 15'h0000;
            data_lines_out <= 8'h00;
            data_lines_oe <= 1'b0;
            chip_select_n <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n <= 1'b1; // [R22]
            save_busy_line_n_out <= 1'b0;
            save_busy_line_n_oe <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    cmd_ready <= b_sync; // [R10]
                    if (cmd_valid && cmd_ready && b_sync) begin
                        cmd_ready <= 1'b0;
                        op <= cmd_op;
                        step <= 3'h0;
                        cnt <= 24'h000000;
                        case (cmd_op)
                            `NVSC_CMD_READ: begin
                                address_bus <= cmd_addr;
                                chip_select_n <= 1'b0; // [R11]
                                output_enable_n <= 1'b0;
                                state <= ST_ACCESS;
                            end
                            `NVSC_CMD_WRITE: begin
                                address_bus <= cmd_addr; // [R13]
                                data_lines_out <= cmd_wdata; // [R14]
                                data_lines_oe <= 1'b1;
                                output_enable_n <= 1'b1; // [R15]
                                // address settles before write enable falls
                                chip_select_n <= 1'b0;
                                state <= ST_ACCESS;
                            end
                            `NVSC_CMD_SAVE, `NVSC_CMD_RESTORE: begin
                                address_bus <= `NVSC_SEQ_A1; // [R1] [R3]
                                chip_select_n <= 1'b0;
                                output_enable_n <= 1'b0;
                                state <= ST_ACCESS;
                            end
                            `NVSC_CMD_HW_SAVE: begin
                                save_busy_line_n_oe <= 1'b1; // [R17]
                                state <= ST_HSB;
                            end
                            default: begin
                                rsp_valid <= 1'b1;
                                state <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_ACCESS: begin
                    // hold controls for the full access time [R12]
                    if (cnt >= ACC_CYC[23:0] - 24'h000001) begin
                        cnt <= 24'h000000;
                        chip_select_n <= 1'b1; // [R6] [R7]
                        output_enable_n <= 1'b1;
                        write_enable_n <= 1'b1;
                        state <= ST_GAP;
                    end else begin
                        cnt <= cnt + 24'h000001;
                        if (op == `NVSC_CMD_WRITE) begin
                            write_enable_n <= 1'b0; // [R13]
                        end
                    end
                end
                ST_GAP: begin
                    // data held one cycle past the rising edge [R14]
                    data_lines_oe <= 1'b0;
                    // two-flop delayed byte, sampled while still selected
                    if (op != `NVSC_CMD_WRITE) begin
                        rsp_rdata <= d_sync; // [R11]
                    end
                    if ((op == `NVSC_CMD_SAVE || op == `NVSC_CMD_RESTORE) &&
                        step != 3'h5) begin
                        // next step directly, nothing interleaved [R2]
                        step <= step + 3'h1;
                        state <= ST_WAIT;
                    end else if (op == `NVSC_CMD_SAVE ||
                        op == `NVSC_CMD_RESTORE) begin
                        cnt <= 24'h000000;
                        state <= ST_BUSY; // [R24]
                    end else begin
                        rsp_valid <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                ST_WAIT: begin
                    address_bus <= seq_addr;
                    chip_select_n <= 1'b0; // [R3]
                    output_enable_n <= 1'b0;
                    state <= ST_ACCESS;
                end
                ST_HSB: begin
                    if (cnt >= HSB_CYC[23:0] - 24'h000001) begin
                        cnt <= 24'h000000;
                        save_busy_line_n_oe <= 1'b0;
                        state <= ST_BUSY;
                    end else begin
                        cnt <= cnt + 24'h000001;
                    end
                end
                ST_BUSY: begin
                    // restores wait out the restore time; saves wait the start delay, then for busy line high [R23] [R19]
                    if (op == `NVSC_CMD_RESTORE) begin
                        if (cnt >= RESTORE_CYC[23:0] - 24'h000001) begin
                            rsp_valid <= 1'b1;
                            state <= ST_IDLE;
                        end else begin
                            cnt <= cnt + 24'h000001;
                        end
                    end else if (cnt >= START_CYC[23:0] && b_sync) begin
                        rsp_valid <= 1'b1; // [R20]
                        state <= ST_IDLE;
                    end else if (cnt >= SAVE_CYC[23:0]) begin
                        cnt <= cnt;
                    end else begin
                        cnt <= cnt + 24'h000001;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// ---- verif/nvsc_host_bench.sv ----
// self-checking bench for the nvsram host controller
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t got %h want %h", $time, g, e); end end
module nvsc_host_bench;
    reg mclk = 1'b0;
    reg sys_rst = 1'b1;
    reg cmd_valid = 1'b0;
    reg [2:0] cmd_op = 3'h0;
    reg [14:0] cmd_addr = 15'h0000;
    reg [7:0] cmd_wdata = 8'h00;
    reg main_supply = 1'b1;
    integer cs_count = 0;
    wire rdy, rv, d_oe, cs_n, oe_n, we_n, sb_out, sb_oe, p_oe, p_boe;
    wire [7:0] rd, d_out, p_q;
    wire [14:0] a;
    wire [7:0] dq = p_oe ? p_q : (d_oe ? d_out : ~p_q);
    wire sb = !(sb_oe && !sb_out) && !p_boe;
    integer failures = 0;
    integer num_checks = 0;
    always #50 mclk = ~mclk;
    always @(negedge cs_n) cs_count = cs_count + 1;
    nvsc_host #(.SAVE_CYC(20), .RESTORE_CYC(10)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(rdy), .rsp_valid(rv), .rsp_rdata(rd), .address_bus(a),
        .data_lines_out(d_out), .data_lines_oe(d_oe), .data_lines_in(dq),
        .chip_select_n(cs_n), .output_enable_n(oe_n), .write_enable_n(we_n),
        .save_busy_line_n_out(sb_out), .save_busy_line_n_oe(sb_oe), .save_busy_line_n_in(sb));
    nvsc_sram_model part (.address_bus(a), .chip_select_n(cs_n), .output_enable_n(oe_n),
        .write_enable_n(we_n), .data_lines(dq), .save_busy_line_n(sb), .dev_q(p_q),
        .main_supply(main_supply), .dev_q_oe(p_oe), .dev_busy_oe(p_boe));
    task automatic cmd(input [2:0] op, input [14:0] ad, input [7:0] wd);
        integer n;
        n = 0;
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = ad;
        cmd_wdata = wd;
        // ready high at a falling edge: the next rising edge takes it
        while (rdy !== 1'b1 && n < 500) begin
            @(negedge mclk);
            n = n + 1;
        end
        @(negedge mclk);
        cmd_valid = 1'b0;
        while (rv !== 1'b1 && n < 4000) begin
            @(negedge mclk);
            n = n + 1;
        end
        if (n >= 4000) begin
            failures++;
            $display("unexpected at %0t command not answered", $time);
        end
    endtask
    task t_write_read;
        cmd(3'h1, 15'h7FFF, 8'hA5);
        cmd(3'h1, 15'h0000, 8'h5A);
        cmd(3'h0, 15'h7FFF, 8'h00);
        `CHK(rd, 8'hA5)
        cmd(3'h0, 15'h0000, 8'h00);
        `CHK(rd, 8'h5A)
    endtask
    task t_soft_ops;
        integer s;
        integer r;
        integer c;
        s = part.save_cnt;
        r = part.restore_cnt;
        cmd(3'h1, 15'h0040, 8'h66);
        cmd(3'h0, 15'h0E38, 8'h00);
        c = cs_count;
        cmd(3'h2, 15'h0000, 8'h00);
        `CHK(part.save_cnt, s + 1)
        `CHK(cs_count, c + 6)
        cmd(3'h2, 15'h0000, 8'h00);
        `CHK(part.save_cnt, s + 2)
        cmd(3'h1, 15'h0040, 8'h99);
        cmd(3'h3, 15'h0000, 8'h00);
        `CHK(part.restore_cnt, r + 1)
        `CHK(part.save_cnt, s + 2)
        cmd(3'h0, 15'h0040, 8'h00);
        `CHK(rd, 8'h66)
    endtask
    task t_hw_save;
        integer s;
        s = part.save_cnt;
        cmd(3'h1, 15'h1234, 8'h3C);
        cmd(3'h4, 15'h0000, 8'h00);
        `CHK(part.save_cnt, s + 1)
        cmd(3'h4, 15'h0000, 8'h00);
        `CHK(part.save_cnt, s + 1)
        cmd(3'h0, 15'h1234, 8'h00);
        `CHK(rd, 8'h3C)
    endtask
    task t_power_cycle;
        integer s;
        integer r;
        s = part.save_cnt;
        r = part.restore_cnt;
        cmd(3'h1, 15'h0100, 8'h77);
        @(negedge mclk);
        main_supply = 1'b0;
        repeat (5) @(negedge mclk);
        `CHK(rdy, 1'b0)
        repeat (20) @(negedge mclk);
        `CHK(part.save_cnt, s + 1)
        `CHK(rdy, 1'b1)
        main_supply = 1'b1;
        repeat (12) @(negedge mclk);
        `CHK(part.restore_cnt, r + 1)
        `CHK(part.restore_we, 1'b1)
        cmd(3'h0, 15'h0100, 8'h00);
        `CHK(rd, 8'h77)
    endtask
    task t_unknown_op;
        integer c;
        c = cs_count;
        cmd(3'h5, 15'h0E38, 8'h00);
        `CHK(cs_count, c)
    endtask
    task complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        t_write_read;
        t_soft_ops;
        t_hw_save;
        t_power_cycle;
        t_unknown_op;
        complete_run;
    end
    initial begin
        #1000000;
        failures++;
        $display("unexpected at %0t watchdog expired", $time);
        complete_run;
    end
endmodule

// ---- verif/nvsc_host_sva.sv ----
// pin-level assertions for the nvsram host controller
`timescale 1ns/1ps
module nvsc_host_sva (
    // clock and command side
    input wire mclk,
    input wire sys_rst,
    input wire cmd_valid,
    input wire [2:0] cmd_op,
    input wire cmd_ready,
    input wire rsp_valid,
    // memory pins
    input wire [14:0] address_bus,
    input wire data_lines_oe,
    input wire chip_select_n,
    input wire output_enable_n,
    input wire write_enable_n,
    input wire save_busy_line_n_in
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence take_rw;
        cmd_valid && cmd_ready && cmd_op <= 3'h1;
    endsequence
    a_rw_latency: assert property (take_rw |=> !rsp_valid[*3] ##1 rsp_valid)
        else $error("answer not four cycles after take");
    a_select_start: assert property (take_rw |=> !chip_select_n)
        else $error("select late");
    a_read_we_high: assert property (!chip_select_n && !output_enable_n |-> write_enable_n)
        else $error("write enable low in read");
    a_write_drive: assert property (!write_enable_n |-> output_enable_n && data_lines_oe)
        else $error("write without data or with output enable");
    a_write_end_data: assert property ($rose(write_enable_n) |-> data_lines_oe)
        else $error("data gone at write end");
    a_addr_stable: assert property (!chip_select_n && !$past(chip_select_n) |-> $stable(address_bus))
        else $error("address moved while selected");
    a_step_gap: assert property ($rose(chip_select_n) |-> chip_select_n[*2])
        else $error("select gap too short");
    a_busy_refuse: assert property (!save_busy_line_n_in[*4] |-> !cmd_ready)
        else $error("ready while busy line low");
endmodule
bind nvsc_host nvsc_host_sva chk (.mclk, .sys_rst, .cmd_valid, .cmd_op, .cmd_ready, .rsp_valid,
    .address_bus, .data_lines_oe, .chip_select_n, .output_enable_n, .write_enable_n,
    .save_busy_line_n_in);

// ---- verif/nvsc_sram_model.sv ----
// behavioural model of the sram with nonvolatile shadow
`timescale 1ns/1ps
`include "nvsc_regs.vh"
module nvsc_sram_model (
    // memory pins
    input wire [14:0] address_bus,
    input wire chip_select_n,
    input wire output_enable_n,
    input wire write_enable_n,
    input wire [7:0] data_lines,
    input wire save_busy_line_n,
    // supply, high while above the switch threshold
    input wire main_supply,
    // pin drivers
    output wire [7:0] dev_q,
    output wire dev_q_oe,
    output reg dev_busy_oe = 1'b0
);
    reg [7:0] mem [0:32767];
    reg [7:0] nv [0:32767];
    reg [2:0] step = 3'h0;
    reg nv_busy = 1'b0;
    reg dirty = 1'b0;
    reg wr_on = 1'b0;
    reg restore_we = 1'b0;
    integer save_cnt = 0;
    integer restore_cnt = 0;
    integer i;
    function [14:0] seq_at(input [2:0] k);
        case (k)
            3'h0: seq_at = `NVSC_SEQ_A1;
            3'h1: seq_at = `NVSC_SEQ_A2;
            3'h2: seq_at = `NVSC_SEQ_A3;
            3'h3: seq_at = `NVSC_SEQ_A4;
            default: seq_at = `NVSC_SEQ_A5;
        endcase
    endfunction
    assign dev_q = mem[address_bus];
    assign dev_q_oe = !chip_select_n && !output_enable_n && write_enable_n
        && save_busy_line_n && !nv_busy;
    task start_save;
        nv_busy = 1'b1;
        dev_busy_oe = 1'b1;
        // erase the shadow, then copy the whole array at once
        for (i = 0; i < 32768; i = i + 1) nv[i] = 8'hFF;
        for (i = 0; i < 32768; i = i + 1) nv[i] = mem[i];
        #1500;
        dev_busy_oe = 1'b0;
        nv_busy = 1'b0;
        dirty = 1'b0;
        save_cnt++;
    endtask
    task run_restore;
        nv_busy = 1'b1;
        #800;
        for (i = 0; i < 32768; i = i + 1) mem[i] = nv[i];
        restore_we = write_enable_n;
        nv_busy = 1'b0;
        restore_cnt++;
    endtask
    // byte taken when the write state ends
    always @(chip_select_n, write_enable_n) begin
        if (!chip_select_n && !write_enable_n && save_busy_line_n && !nv_busy) begin
            wr_on = 1'b1;
        end else if (wr_on) begin
            mem[address_bus] = data_lines;
            dirty = 1'b1;
            step = 3'h0;
            wr_on = 1'b0;
        end
    end
    always @(negedge chip_select_n) begin
        if (write_enable_n && save_busy_line_n && !nv_busy) begin
            if (step == 3'h5) begin
                step = 3'h0;
                if (address_bus == `NVSC_SEQ_SAVE) start_save;
                else if (address_bus == `NVSC_SEQ_RESTORE) run_restore;
            end else if (address_bus == seq_at(step)) step = step + 3'h1;
            else step = {2'h0, address_bus == `NVSC_SEQ_A1};
        end
    end
    always @(negedge save_busy_line_n) if (!nv_busy && dirty) start_save;
    always @(negedge main_supply) if (!nv_busy && dirty) start_save;
    always @(posedge main_supply) if (!nv_busy) run_restore;
endmodule
